// ===== hw/asrl_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module asrl_fifo #(
  parameter int unsigned WIDTH = asrl_pkg::FIFO_WIDTH,
  parameter int unsigned DEPTH = asrl_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // filling side
  input  wire logic                  in_valid,
  output logic                       in_ready,
  input  wire logic [WIDTH-1:0]      in_data,
  // draining side
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output logic [WIDTH-1:0]           out_data,
  // occupancy
  output logic [$clog2(DEPTH):0]     level
);

  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_idx;
    logic [AW-1:0]               rd_idx;
    logic [AW:0]                 count;
  } asrl_fifo_s;

  asrl_fifo_s s_q;
  asrl_fifo_s s_d;
  logic       push;
  logic       pop;

  // index wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_shape
    $error("asrl_fifo: DEPTH must be a power of two of at least 2, WIDTH at least 1");
  end

  always_comb begin
    in_ready  = (s_q.count != (AW + 1)'(DEPTH));
    out_valid = (s_q.count != '0);
    out_data  = s_q.mem[s_q.rd_idx];
    level     = s_q.count;
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    s_d       = s_q;
    if (push) begin
      s_d.mem[s_q.wr_idx] = in_data;
      s_d.wr_idx          = s_q.wr_idx + 1'b1;
    end
    if (pop) begin
      s_d.rd_idx = s_q.rd_idx + 1'b1;
    end
    s_d.count = s_q.count + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ===== hw/asrl_pkg.sv
// shared constants, types and decode functions of the addressable shift register
// ----------------------------------------------------------------------------
// Contract
// - length equals 8*bit3 + 4*bit2 + 2*bit1 + bit0 + 1, from 1 to 16
// - select 0000 gives one stage of delay, select 1111 gives sixteen
// - sixteen stages always stored; select only picks the tap feeding data out
// - sixteen-bit preset value, four hex digits, leftmost digit most significant
// - preset value defaults to all zeros, clearing every stage
// - stages load the preset at start; both outputs show it at once
// - rising-edge build captures serial input on permitted low-to-high edges
// - falling-edge build captures serial input on permitted high-to-low edges
// - each permitted edge moves every bit one stage up; new bit enters stage 0
// - enable builds shift only while enable is high, otherwise hold all stages
// - data out is the selected stage; after an edge it shows the stage below
// - cascade out is always the last stage, taking stage 14 on each edge
// ----------------------------------------------------------------------------
package asrl_pkg;

  // ----------------------------------------------------------------------------
  // sizes and preset
  // ----------------------------------------------------------------------------
  localparam int unsigned STAGES       = 16;
  localparam int unsigned SEL_W        = 4;
  localparam logic [15:0] INIT_DEFAULT = 16'h0000;
  localparam int unsigned FIFO_WIDTH   = 1;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam int unsigned CNT_W        = 16;

  // ----------------------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------------------
  localparam logic [31:0] OFF_CTRL   = 32'h0000_0000;
  localparam logic [31:0] OFF_STAGES = 32'h0000_0004;
  localparam logic [31:0] OFF_TAP    = 32'h0000_0008;
  localparam logic [31:0] OFF_PUSH   = 32'h0000_000C;
  localparam logic [31:0] OFF_COUNT  = 32'h0000_0010;

  // field positions and reset values
  localparam int unsigned CTRL_SRC_BIT  = 0;
  localparam int unsigned TAP_DATA_BIT  = 4;
  localparam int unsigned TAP_CASC_BIT  = 5;
  localparam int unsigned PUSH_BIT      = 0;
  localparam logic        CTRL_SRC_RST  = 1'b0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

  typedef enum logic [2:0] {
    REG_CTRL   = 3'h0,
    REG_STAGES = 3'h1,
    REG_TAP    = 3'h2,
    REG_PUSH   = 3'h3,
    REG_COUNT  = 3'h4
  } asrl_reg_e;

  // ----------------------------------------------------------------------------
  // state of the top module
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [STAGES-1:0] stages;
    logic [CNT_W-1:0]  shift_cnt;
    logic              sclk_meta;
    logic              sclk_sync;
    logic              sclk_prev;
    logic              en_meta;
    logic              en_sync;
    logic              din_meta;
    logic              din_sync;
    logic              src_fifo;
    logic              aw_pend;
    logic              aw_hit;
    asrl_reg_e         aw_reg;
    logic              w_pend;
    logic              w_bit;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } asrl_state_s;

  // word index of a byte address
  function automatic asrl_reg_e asrl_reg(input logic [31:0] addr);
    return asrl_reg_e'(addr[4:2]);
  endfunction

  // address falls on a mapped word
  function automatic logic asrl_hit(input logic [31:0] addr);
    return (addr[31:5] == 27'h0) && (addr[4:2] <= OFF_COUNT[4:2]);
  endfunction

endpackage

// ===== hw/asrl_top.sv
// addressable sixteen-stage shift register with cascade tap and axi4-lite access
`timescale 1ns/1ps
module asrl_top #(
  parameter logic [15:0] INIT         = asrl_pkg::INIT_DEFAULT,
  parameter bit          FALLING_EDGE = 1'b0,
  parameter bit          HAS_ENABLE   = 1'b1,
  parameter int unsigned FIFO_DEPTH   = asrl_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  // axi4-lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // fabric pins, asynchronous to aclk
  input  wire logic        shift_clk,
  input  wire logic        shift_enable,
  input  wire logic        serial_in,
  // tap select from fabric logic on aclk
  input  wire logic        length_select_bit3,
  input  wire logic        length_select_bit2,
  input  wire logic        length_select_bit1,
  input  wire logic        length_select_bit0,
  // shift register outputs
  output logic             data_out,
  output logic             cascade_out
);

  localparam int unsigned LVL_W = $clog2(FIFO_DEPTH) + 1;

  // ----------------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------------
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 2 ** 16) begin : g_bad_depth
    $error("asrl_top: FIFO_DEPTH out of range");
  end

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  localparam asrl_pkg::asrl_state_s RST_STATE = '{
    stages:   INIT,
    src_fifo: asrl_pkg::CTRL_SRC_RST,
    aw_reg:   asrl_pkg::REG_CTRL,
    bresp:    asrl_pkg::RESP_OKAY,
    rresp:    asrl_pkg::RESP_OKAY,
    default:  '0
  };

  asrl_pkg::asrl_state_s     s_q;
  asrl_pkg::asrl_state_s     s_d;
  logic [asrl_pkg::SEL_W-1:0] sel;
  logic                      edge_rise;
  logic                      edge_fall;
  logic                      edge_hit;
  logic                      permit;
  logic                      feed_ok;
  logic                      shift;
  logic                      new_bit;
  logic                      wr_go;
  logic                      wr_push;
  logic                      wr_done;
  logic                      fifo_in_valid;
  logic                      fifo_in_ready;
  logic                      fifo_out_valid;
  logic                      fifo_out_ready;
  logic                      fifo_out_data;
  logic [LVL_W-1:0]          fifo_level;
  logic [31:0]               rd_word;

  // ----------------------------------------------------------------------------
  // software bit source
  // ----------------------------------------------------------------------------
  asrl_fifo #(
    .WIDTH (asrl_pkg::FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (s_q.w_bit),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // ----------------------------------------------------------------------------
  // tap select and outputs
  // ----------------------------------------------------------------------------
  // the select is a plain binary index: stage n gives a delay of n + 1
  assign sel = {length_select_bit3, length_select_bit2,
                length_select_bit1, length_select_bit0};

  // no clock in this path, so a new select shows on data_out in the same cycle
  assign data_out    = s_q.stages[sel];
  assign cascade_out = s_q.stages[asrl_pkg::STAGES-1];

  // ----------------------------------------------------------------------------
  // shift control
  // ----------------------------------------------------------------------------
  always_comb begin
    edge_rise = s_q.sclk_sync & ~s_q.sclk_prev;
    edge_fall = ~s_q.sclk_sync & s_q.sclk_prev;
    // edge choice is fixed at build time
    edge_hit  = FALLING_EDGE ? edge_fall : edge_rise;
    permit    = HAS_ENABLE ? s_q.en_sync : 1'b1;
    // an edge with the fifo empty is dropped, so no stage takes a bit the fifo does not hold
    feed_ok   = s_q.src_fifo ? fifo_out_valid : 1'b1;
    shift     = edge_hit & permit & feed_ok;
    new_bit   = s_q.src_fifo ? fifo_out_data : s_q.din_sync;
    fifo_out_ready = shift & s_q.src_fifo;
  end

  // ----------------------------------------------------------------------------
  // write channel decode
  // ----------------------------------------------------------------------------
  always_comb begin
    awready       = ~s_q.aw_pend & ~s_q.bvalid;
    wready        = ~s_q.w_pend & ~s_q.bvalid;
    wr_go         = s_q.aw_pend & s_q.w_pend & ~s_q.bvalid;
    wr_push       = s_q.aw_hit & (s_q.aw_reg == asrl_pkg::REG_PUSH) & s_q.w_lane0;
    // a push into a full fifo holds the response back until room appears
    fifo_in_valid = wr_go & wr_push;
    wr_done       = wr_go & (~wr_push | fifo_in_ready);
  end

  // ----------------------------------------------------------------------------
  // read data mux
  // ----------------------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (asrl_pkg::asrl_reg(araddr))
      asrl_pkg::REG_CTRL: begin
        rd_word[asrl_pkg::CTRL_SRC_BIT] = s_q.src_fifo;
      end
      asrl_pkg::REG_STAGES: begin
        rd_word[asrl_pkg::STAGES-1:0] = s_q.stages;
      end
      asrl_pkg::REG_TAP: begin
        rd_word[asrl_pkg::SEL_W-1:0]       = sel;
        rd_word[asrl_pkg::TAP_DATA_BIT]    = data_out;
        rd_word[asrl_pkg::TAP_CASC_BIT]    = cascade_out;
      end
      asrl_pkg::REG_PUSH: begin
        rd_word[LVL_W-1:0] = fifo_level;
      end
      asrl_pkg::REG_COUNT: begin
        rd_word[asrl_pkg::CNT_W-1:0] = s_q.shift_cnt;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
    if (!asrl_pkg::asrl_hit(araddr)) begin
      rd_word = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // two flops on every asynchronous pin before anything reads it
    s_d.sclk_meta = shift_clk;
    s_d.sclk_sync = s_q.sclk_meta;
    s_d.sclk_prev = s_q.sclk_sync;
    s_d.en_meta   = shift_enable;
    s_d.en_sync   = s_q.en_meta;
    s_d.din_meta  = serial_in;
    s_d.din_sync  = s_q.din_meta;

    // stage 0 takes the new bit, every other stage the one below it
    if (shift) begin
      s_d.stages = {s_q.stages[asrl_pkg::STAGES-2:0], new_bit};
    end

    // count clear and a shift in one cycle: the shift is still counted
    if (wr_done && s_q.aw_hit && s_q.aw_reg == asrl_pkg::REG_COUNT && s_q.w_lane0) begin
      s_d.shift_cnt = asrl_pkg::CNT_W'(shift);
    end else begin
      s_d.shift_cnt = s_q.shift_cnt + asrl_pkg::CNT_W'(shift);
    end

    // write address and data are taken in either order
    if (awvalid && awready) begin
      s_d.aw_pend = 1'b1;
      s_d.aw_hit  = asrl_pkg::asrl_hit(awaddr);
      s_d.aw_reg  = asrl_pkg::asrl_reg(awaddr);
    end
    if (wvalid && wready) begin
      s_d.w_pend  = 1'b1;
      s_d.w_bit   = wdata[asrl_pkg::PUSH_BIT];
      s_d.w_lane0 = wstrb[0];
    end

    if (wr_done) begin
      s_d.aw_pend = 1'b0;
      s_d.w_pend  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = s_q.aw_hit ? asrl_pkg::RESP_OKAY : asrl_pkg::RESP_DECERR;
      if (s_q.aw_hit && s_q.aw_reg == asrl_pkg::REG_CTRL && s_q.w_lane0) begin
        s_d.src_fifo = s_q.w_bit;
      end
    end else if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end

    // one read in flight; the next address waits for the data to be taken
    if (arvalid && arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_word;
      s_d.rresp  = asrl_pkg::asrl_hit(araddr) ? asrl_pkg::RESP_OKAY
                                              : asrl_pkg::RESP_DECERR;
    end else if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // bus outputs
  // ----------------------------------------------------------------------------
  assign arready = ~s_q.rvalid;
  assign rvalid  = s_q.rvalid;
  assign rdata   = s_q.rdata;
  assign rresp   = s_q.rresp;
  assign bvalid  = s_q.bvalid;
  assign bresp   = s_q.bresp;

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  // reset stands in for configuration: stages come back to the preset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ===== verif/asrl_checker.sv
// port-level assertions for the addressable shift register
`timescale 1ns/1ps
module asrl_checker (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        awready,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  // fabric side
  input wire logic        shift_clk,
  input wire logic        shift_enable,
  input wire logic        length_select_bit3,
  input wire logic        length_select_bit2,
  input wire logic        length_select_bit1,
  input wire logic        length_select_bit0,
  input wire logic        data_out,
  input wire logic        cascade_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------------------
  // a pin change reaches the stages on the third edge, so six quiet cycles leave no shift in flight
  sequence s_clk_quiet;
    $stable(shift_clk) [*6];
  endsequence
  sequence s_en_low;
    (!shift_enable) [*6];
  endsequence
  sequence s_sel_held;
    $stable(length_select_bit3) && $stable(length_select_bit2) &&
    $stable(length_select_bit1) && $stable(length_select_bit0);
  endsequence
  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped or changed before bready");
  a_bresp_clear: assert property (bvalid && bready |=> !bvalid)
    else $error("write response stayed after its handshake");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped or changed before rready");
  a_read_latency: assert property (arvalid && arready |=> rvalid)
    else $error("read data not offered one cycle after the address");
  a_write_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write channel ready while a response is pending");
  a_read_refuse: assert property (rvalid |-> !arready)
    else $error("read address ready while read data is pending");
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> !bvalid && !rvalid && arready)
    else $error("bus not idle after reset");
  a_cascade_hold: assert property (s_clk_quiet |-> $stable(cascade_out))
    else $error("cascade output moved without a shift edge");
  a_tap_stable: assert property (s_clk_quiet ##0 s_sel_held |-> $stable(data_out))
    else $error("data output moved without shift or select change");
  a_enable_hold: assert property (s_en_low |-> $stable(cascade_out))
    else $error("stages shifted while enable was low");
endmodule

// ===== verif/asrl_fabric.sv
// behavioural fabric logic driving the shift pins of the register
`timescale 1ns/1ps
module asrl_fabric (
  // clock
  input wire logic aclk,
  // command from the bench
  input wire logic req,
  input wire logic req_bit,
  input wire logic req_en,
  output logic     busy,
  // pins toward the register
  output logic     shift_clk,
  output logic     shift_enable,
  output logic     serial_in
);
  initial begin
    busy = 1'b0;
    shift_clk = 1'b0;
    shift_enable = 1'b0;
    serial_in = 1'b0;
    forever begin
      @(posedge aclk);
      if (req) begin
        busy <= 1'b1;
        serial_in <= req_bit;
        shift_enable <= req_en;
        // data and enable settle well ahead of the edge
        repeat (4) @(posedge aclk);
        shift_clk <= 1'b1;
        repeat (4) @(posedge aclk);
        shift_clk <= 1'b0;
        // data also holds through the falling edge, then stale data leaves the line
        repeat (4) @(posedge aclk);
        serial_in <= ~req_bit;
        repeat (2) @(posedge aclk);
        busy <= 1'b0;
      end
    end
  end
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the addressable shift register
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] INIT_V = 16'hA5C3;
  localparam int          TMO    = 200;
  localparam logic [31:0] A_CTRL = asrl_pkg::OFF_CTRL;
  localparam logic [31:0] A_STG  = asrl_pkg::OFF_STAGES;
  localparam logic [31:0] A_TAP  = asrl_pkg::OFF_TAP;
  localparam logic [31:0] A_PUSH = asrl_pkg::OFF_PUSH;
  localparam logic [31:0] A_CNT  = asrl_pkg::OFF_COUNT;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, shift_clk, shift_enable, serial_in;
  logic        data_out, cascade_out, f_req, f_bit, f_en, f_busy, f_data, f_casc;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  sel;
  logic [15:0] exp_q, exp_f;
  int          n_errors, checks_done;

  asrl_top #(.INIT(INIT_V)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .shift_clk(shift_clk), .shift_enable(shift_enable),
    .serial_in(serial_in), .length_select_bit3(sel[3]), .length_select_bit2(sel[2]),
    .length_select_bit1(sel[1]), .length_select_bit0(sel[0]), .data_out(data_out),
    .cascade_out(cascade_out));
  // enable-less falling-edge unit with the default preset; its enable pin idles high
  asrl_top #(.FALLING_EDGE(1'b1), .HAS_ENABLE(1'b0)) DUT_FALL (
    .aclk(aclk), .aresetn(aresetn), .awaddr(32'h0), .awprot(3'h0), .awvalid(1'b0),
    .awready(), .wdata(32'h0), .wstrb(4'h0), .wvalid(1'b0), .wready(), .bresp(),
    .bvalid(), .bready(1'b0), .araddr(32'h0), .arprot(3'h0), .arvalid(1'b0), .arready(),
    .rdata(), .rresp(), .rvalid(), .rready(1'b0), .shift_clk(shift_clk),
    .shift_enable(1'b1), .serial_in(serial_in), .length_select_bit3(sel[3]),
    .length_select_bit2(sel[2]), .length_select_bit1(sel[1]), .length_select_bit0(sel[0]),
    .data_out(f_data), .cascade_out(f_casc));
  asrl_fabric FAB (.aclk(aclk), .req(f_req), .req_bit(f_bit), .req_en(f_en), .busy(f_busy),
    .shift_clk(shift_clk), .shift_enable(shift_enable), .serial_in(serial_in));

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] er = asrl_pkg::RESP_OKAY, input int lag = 0);
    logic       ta, tw, tv;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    for (int n = 0; n < TMO; n++) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      tv = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      // a late bready lets the response stand unanswered for a few cycles
      if (n == lag) bready <= 1'b1;
      if (tv && n > lag) break;
    end
    bready <= 1'b0;
    chk("bvalid seen", 32'h1, {31'h0, tv});
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e,
                    input logic [1:0] er = asrl_pkg::RESP_OKAY, input int lag = 0);
    logic        ta, tv;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    for (int n = 0; n < TMO; n++) begin
      @(negedge aclk);
      ta = arready;
      tv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (n == lag) rready <= 1'b1;
      if (tv && n > lag) break;
    end
    rready <= 1'b0;
    chk("rvalid seen", 32'h1, {31'h0, tv});
    chk($sformatf("rdata at %h", a), e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic shift(input logic b, input logic en);
    @(posedge aclk);
    f_bit <= b;
    f_en <= en;
    f_req <= 1'b1;
    @(posedge aclk);
    f_req <= 1'b0;
    for (int n = 0; n < TMO; n++) begin
      @(negedge aclk);
      // rising edge already taken here, falling edge not yet
      if (n == 8) chk("f_data before fall", {31'h0, exp_f[sel]}, {31'h0, f_data});
      if (!f_busy) break;
    end
    chk("fabric idle", 32'h0, {31'h0, f_busy});
    exp_f = {exp_f[14:0], b};
    chk("f_data", {31'h0, exp_f[sel]}, {31'h0, f_data});
    chk("f_casc", {31'h0, exp_f[15]}, {31'h0, f_casc});
  endtask

  // select moves with no clock edge in between
  task automatic sweep(input logic [15:0] e);
    for (int s = 0; s < 16; s++) begin
      @(posedge aclk);
      sel <= 4'(s);
      @(negedge aclk);
      chk($sformatf("data_out sel %0d", s), {31'h0, e[s]}, {31'h0, data_out});
      chk($sformatf("f_data sel %0d", s), {31'h0, exp_f[s]}, {31'h0, f_data});
    end
  endtask

  task automatic t_reset();
    rd(A_STG, {16'h0, INIT_V});
    chk("cascade_out", {31'h0, INIT_V[15]}, {31'h0, cascade_out});
    sweep(INIT_V);
    rd(A_TAP, {26'h0, INIT_V[15], INIT_V[15], 4'hF});
    rd(A_CTRL, 32'h0, asrl_pkg::RESP_OKAY, 3);
    rd(32'h0000_0020, 32'h0, asrl_pkg::RESP_DECERR);
    wr(32'h0000_0020, 32'h1, asrl_pkg::RESP_DECERR, 3);
  endtask

  task automatic t_shift();
    logic [15:0] pat;
    pat = 16'h3C96;
    exp_q = INIT_V;
    sel <= 4'h5;
    for (int i = 0; i < 16; i++) begin
      shift(pat[i], 1'b1);
      exp_q = {exp_q[14:0], pat[i]};
      chk("data_out", {31'h0, exp_q[5]}, {31'h0, data_out});
      chk("cascade_out", {31'h0, exp_q[15]}, {31'h0, cascade_out});
    end
    rd(A_STG, {16'h0, exp_q});
    rd(A_CNT, 32'h10);
    sweep(exp_q);
    wr(A_CNT, 32'h0);
    rd(A_CNT, 32'h0);
  endtask

  task automatic t_enable();
    shift(1'b1, 1'b0);
    shift(1'b1, 1'b0);
    rd(A_STG, {16'h0, exp_q});
    rd(A_CNT, 32'h0);
  endtask

  // pin carries the inverse bit so only the buffer can explain the result
  task automatic t_fifo();
    logic [8:0] pb;
    pb = 9'h1A5;
    wr(A_CTRL, 32'h1);
    rd(A_CTRL, 32'h1);
    for (int i = 0; i < 8; i++) wr(A_PUSH, {31'h0, pb[i]});
    rd(A_PUSH, 32'h8);
    fork
      wr(A_PUSH, {31'h0, pb[8]});
      begin
        repeat (20) @(posedge aclk);
        @(negedge aclk);
        chk("bvalid while full", 32'h0, {31'h0, bvalid});
        shift(~pb[0], 1'b1);
      end
    join
    for (int i = 0; i < 9; i++) begin
      if (i > 0) shift(~pb[i], 1'b1);
      exp_q = {exp_q[14:0], pb[i]};
    end
    rd(A_STG, {16'h0, exp_q});
    rd(A_PUSH, 32'h0);
    shift(1'b1, 1'b1);
    rd(A_STG, {16'h0, exp_q});
    rd(A_CNT, 32'h9);
    wr(A_CTRL, 32'h0);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    report_and_stop();
  end

  initial begin
    {n_errors, checks_done} = '0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, f_req, f_bit, f_en} = '0;
    {awaddr, wdata, araddr, sel, exp_f} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_shift();
    t_enable();
    t_fifo();
    report_and_stop();
  end
endmodule

bind asrl_top asrl_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .awready(awready), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .shift_clk(shift_clk), .shift_enable(shift_enable),
  .length_select_bit3(length_select_bit3), .length_select_bit2(length_select_bit2),
  .length_select_bit1(length_select_bit1), .length_select_bit0(length_select_bit0),
  .data_out(data_out), .cascade_out(cascade_out));
